//--- include/xmb_pkg.sv
// shared constants and types for the extended memory bus control block
package xmb_pkg;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_IOKEY  = 4'h8;
  // control register fields
  localparam int CTRL_PROT_EN = 0;
  localparam int CTRL_PROT_OFF = 1;
  // status register fields
  localparam int ST_EXT_MODE  = 0;
  localparam int ST_LOCKOUT   = 1;
  localparam int ST_LOCK_PEND = 2;
  localparam int ST_PROT_EN   = 3;
  localparam int ST_BUSY      = 4;
  localparam int ST_KEY_LSB   = 8;
  localparam int ST_IOKEY_LSB = 12;
  localparam int ST_MIR_LSB   = 16;
  // microinstruction decode values
  localparam logic [1:0] SEQ_ZERO   = 2'h0;
  localparam logic [3:0] UOP_MEMCTL = 4'hD;
  localparam logic [1:0] LB_MEMCTL  = 2'h3;
  // key field position on the alu output bus
  localparam int KEY_SRC_LSB = 12;
  // read data arrives no sooner than this many microinstructions after acceptance
  localparam logic [1:0] MIR_MIN_STEPS = 2'h2;
  // reset values and response codes
  localparam logic [3:0]  KEY_RST  = 4'h0;
  localparam logic [15:0] MIR_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // memory cycle sequencing, gray along idle -> wait accept -> in flight
  typedef enum logic [1:0]
  {
    CYC_IDLE   = 2'b00,
    CYC_ASK    = 2'b01,
    CYC_FLIGHT = 2'b11
  } xmb_cyc_type;
endpackage : xmb_pkg

//--- verilog/xmb_top.sv
// extended memory bus control: 64k mode, lockout, key map, protection, mir timing
// Functional notes
// [R01] high address bit forced low outside 64k mode
// [R02] page zero suppresses 16-bit addressing
// [R03] 64k mode sticky until disable or reset
// [R04] enable decode: zero fields, 1101, 11, mode bit
// [R05] disable decode: zero fields, 1101, 11, carry 1x
// [R06] lockout here refuses other port accesses
// [R07] lockout takes effect only on memory win
// [R08] carry bit0/reg-a bit0 pair sets or resets lockout
// [R09] system reset removes lockout
// [R10] key loaded from alu bits 12-15
// [R11] key drives map input bits 15-18
// [R12] 64k mode ors address bit 15 in
// [R13] dma cycles use the i/o key
// [R14] key readable on bus b status
// [R15] violating write blocked, two interrupts raised
// [R16] only i/o instructions disable protection
// [R17] mir as address source uses new value
// [R18] dma and pma never touch mir
// [R19] read data no sooner than second step
// [R20] stall while new cycle awaits acceptance
// [R21] priority port avoids lockout while processor locked; not modelled, every other_req is refused while lockout is held
`timescale 1ns/1ps
module xmb_top
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // microinstruction fields, valid with uinstr_exec
  input  wire logic        uinstr_exec,
  input  wire logic [1:0]  sequence_select_code,
  input  wire logic        transfer_bit,
  input  wire logic [3:0]  micro_op_code,
  input  wire logic [1:0]  latch_b_code,
  input  wire logic        mode_flag_bit,
  input  wire logic [1:0]  carry_ctrl_field,
  input  wire logic [3:0]  reg_a_spec,
  input  wire logic        page_zero_active,
  // key load and status read
  input  wire logic        key_load,
  input  wire logic [15:0] alu_out,
  input  wire logic        status_read,
  output logic [3:0]       status_key,
  // processor memory cycle request
  input  wire logic        cyc_start,
  input  wire logic        cyc_write,
  input  wire logic        addr_from_mir,
  input  wire logic [15:0] mem_addr_reg,
  input  wire logic        prot_violation,
  output logic             uinstr_stall,
  // memory control side
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [18:0]      map_input,
  input  wire logic        mem_accept,
  input  wire logic        rdata_valid,
  input  wire logic        rdata_dma,
  input  wire logic [15:0] rdata,
  input  wire logic        io_cycle_active,
  // shared lockout with the second port
  input  wire logic        other_req,
  input  wire logic        other_lockout,
  output logic             lockout,
  output logic             other_refuse,
  // protection interrupts
  output logic             prot_int,
  output logic             io_int_req
);

  // all block state in one record
  typedef struct packed
  {
    logic                    ext_mode;
    logic                    lock_pend;
    logic                    lock_clr_pend;
    logic                    lockout;
    logic                    other_refuse;
    logic [3:0]              key;
    logic [3:0]              io_key;
    logic [3:0]              status_key;
    logic                    prot_en;
    logic [15:0]             mir;
    xmb_pkg::xmb_cyc_type    cyc;
    logic                    cyc_we;
    logic                    cyc_read;
    logic                    use_mir;
    logic [1:0]              steps;
    logic                    data_pend;
    logic [15:0]             data_hold;
    logic                    stall;
    logic                    mem_req;
    logic                    mem_we;
    logic [15:0]             mem_addr;
    logic [18:0]             map_input;
    logic                    prot_int;
    logic                    io_int_req;
    logic                    aw_have;
    logic [3:0]              aw_addr;
    logic                    w_have;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } xmb_state_type;

  xmb_state_type st_q;
  xmb_state_type st_d;

  // shared decode of the memory control microinstruction group
  logic        memctl_op;
  logic        mir_now;
  logic [15:0] mir_new;
  logic [15:0] addr_src;
  logic        wide_ok;
  logic [3:0]  key_sel;
  logic        wr_go;

  always_comb
  begin
    memctl_op = uinstr_exec && sequence_select_code == xmb_pkg::SEQ_ZERO && !transfer_bit
                && micro_op_code == xmb_pkg::UOP_MEMCTL && latch_b_code == xmb_pkg::LB_MEMCTL;
    mir_now   = 1'b0;
    mir_new   = st_q.mir;
    addr_src  = 16'h0000;
    wide_ok   = 1'b0;
    key_sel   = 4'h0;
    wr_go     = 1'b0;
    st_d      = st_q;

    // 64k mode flag; disable checked after enable so disable wins on a clash
    if (memctl_op && mode_flag_bit)
      st_d.ext_mode = 1'b1; // [R04] [R03]
    if (memctl_op && carry_ctrl_field[1])
      st_d.ext_mode = 1'b0; // [R05] [R03]

    // lockout requests wait for our bus to win memory before they count
    if (memctl_op && carry_ctrl_field[0] && !reg_a_spec[0])
    begin
      st_d.lock_pend     = 1'b1; // [R08]
      st_d.lock_clr_pend = 1'b0;
    end
    else if (memctl_op && !carry_ctrl_field[0] && reg_a_spec[0])
    begin
      st_d.lock_clr_pend = 1'b1; // [R08]
      st_d.lock_pend     = 1'b0;
    end
    if (st_q.cyc == xmb_pkg::CYC_ASK && mem_accept)
    begin
      if (st_d.lock_pend && !other_lockout)
      begin
        st_d.lockout   = 1'b1; // [R07]
        st_d.lock_pend = 1'b0;
      end
      if (st_d.lock_clr_pend)
      begin
        st_d.lockout       = 1'b0;
        st_d.lock_clr_pend = 1'b0;
      end
    end
    // refusal follows the lockout we actually hold
    st_d.other_refuse = st_q.lockout && other_req; // [R06]

    // processor key and the key seen by the status word
    if (key_load)
      st_d.key = alu_out[xmb_pkg::KEY_SRC_LSB +: 4]; // [R10]
    if (status_read)
      st_d.status_key = io_cycle_active ? st_q.io_key : st_q.key; // [R14]

    // mir: only processor reads past the second step update it
    if (rdata_valid && !rdata_dma && st_q.cyc_read)
    begin
      st_d.data_pend = 1'b1; // [R18]
      st_d.data_hold = rdata;
    end
    if (st_d.data_pend && st_q.steps >= xmb_pkg::MIR_MIN_STEPS)
    begin
      mir_now        = 1'b1; // [R19]
      mir_new        = st_d.data_hold;
      st_d.mir       = st_d.data_hold;
      st_d.data_pend = 1'b0;
      st_d.cyc_read  = 1'b0;
      if (st_q.cyc == xmb_pkg::CYC_FLIGHT)
        st_d.cyc = xmb_pkg::CYC_IDLE;
    end
    if (uinstr_exec && st_q.steps != 2'h3)
      st_d.steps = st_q.steps + 2'h1;

    // interrupt pair is a one-cycle pulse from the request that trips it
    st_d.prot_int   = 1'b0;
    st_d.io_int_req = 1'b0;

    // cycle sequencing; a write completes at acceptance
    case (st_q.cyc)
      xmb_pkg::CYC_IDLE:
      begin
        if (cyc_start)
        begin
          wr_go        = cyc_write && !(st_q.prot_en && prot_violation); // [R15]
          st_d.prot_int   = cyc_write && st_q.prot_en && prot_violation; // [R15]
          st_d.io_int_req = cyc_write && st_q.prot_en && prot_violation; // [R15]
          if (!cyc_write || wr_go)
          begin
            st_d.cyc     = xmb_pkg::CYC_ASK;
            st_d.cyc_we  = wr_go;
            st_d.use_mir = addr_from_mir;
          end
        end
      end
      xmb_pkg::CYC_ASK:
      begin
        if (mem_accept && !other_lockout)
        begin
          st_d.steps    = 2'h0;
          st_d.cyc_read = !st_q.cyc_we;
          st_d.cyc      = st_q.cyc_we ? xmb_pkg::CYC_IDLE : xmb_pkg::CYC_FLIGHT;
        end
      end
      xmb_pkg::CYC_FLIGHT:
      begin
        // a new request here waits until the read lands; it is screened as well
        if (cyc_start && mir_now)
        begin
          wr_go           = cyc_write && !(st_q.prot_en && prot_violation); // [R15]
          st_d.prot_int   = cyc_write && !wr_go; // [R15]
          st_d.io_int_req = cyc_write && !wr_go; // [R15]
          if (!cyc_write || wr_go)
          begin
            st_d.cyc     = xmb_pkg::CYC_ASK;
            st_d.cyc_we  = wr_go;
            st_d.use_mir = addr_from_mir;
          end
        end
      end
      default:
        st_d.cyc = xmb_pkg::CYC_IDLE;
    endcase
    st_d.stall   = cyc_start && st_q.cyc != xmb_pkg::CYC_IDLE
                   && !(st_q.cyc == xmb_pkg::CYC_ASK && mem_accept); // [R20]
    st_d.mem_req = st_d.cyc == xmb_pkg::CYC_ASK && !other_lockout; // [R06]
    st_d.mem_we  = st_d.cyc == xmb_pkg::CYC_ASK && st_d.cyc_we;

    // address path; bypass keeps mir source fresh when data lands now
    addr_src      = st_d.use_mir ? mir_new : mem_addr_reg; // [R17]
    wide_ok       = st_d.ext_mode && !page_zero_active; // [R02]
    st_d.mem_addr = {addr_src[15] & wide_ok, addr_src[14:0]}; // [R01]
    key_sel       = io_cycle_active ? st_q.io_key : st_d.key; // [R13]
    st_d.map_input = {key_sel[3:1], key_sel[0] | (addr_src[15] & wide_ok),
                      addr_src[14:0]}; // [R11] [R12]

    // axi4-lite write channels, taken in either order
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = xmb_pkg::RESP_OK;
      case (st_q.aw_addr)
        xmb_pkg::OFF_CTRL:
        begin
          // bus writes stand in for i/o instructions
          if (st_q.w_strb[0] && st_q.w_data[xmb_pkg::CTRL_PROT_EN])
            st_d.prot_en = 1'b1;
          if (st_q.w_strb[0] && st_q.w_data[xmb_pkg::CTRL_PROT_OFF])
            st_d.prot_en = 1'b0; // [R16]
        end
        xmb_pkg::OFF_IOKEY:
        begin
          if (st_q.w_strb[0])
            st_d.io_key = st_q.w_data[3:0];
        end
        xmb_pkg::OFF_STATUS:
          st_d.bresp = xmb_pkg::RESP_OK;
        default:
          st_d.bresp = xmb_pkg::RESP_ERR;
      endcase
    end
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready  = !st_d.w_have && !st_d.bvalid;

    // axi4-lite read channel, one beat after the address
    if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
    if (s_axi_arvalid && st_q.arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = xmb_pkg::RESP_OK;
      st_d.rdata  = 32'h00000000;
      case (s_axi_araddr)
        xmb_pkg::OFF_CTRL:
          st_d.rdata[xmb_pkg::CTRL_PROT_EN] = st_q.prot_en;
        xmb_pkg::OFF_STATUS:
        begin
          st_d.rdata[xmb_pkg::ST_EXT_MODE]  = st_q.ext_mode;
          st_d.rdata[xmb_pkg::ST_LOCKOUT]   = st_q.lockout;
          st_d.rdata[xmb_pkg::ST_LOCK_PEND] = st_q.lock_pend;
          st_d.rdata[xmb_pkg::ST_PROT_EN]   = st_q.prot_en;
          st_d.rdata[xmb_pkg::ST_BUSY]      = st_q.cyc != xmb_pkg::CYC_IDLE;
          st_d.rdata[xmb_pkg::ST_KEY_LSB +: 4]   = st_q.key;
          st_d.rdata[xmb_pkg::ST_IOKEY_LSB +: 4] = st_q.io_key;
          st_d.rdata[xmb_pkg::ST_MIR_LSB +: 16]  = st_q.mir;
        end
        xmb_pkg::OFF_IOKEY:
          st_d.rdata[3:0] = st_q.io_key;
        default:
          st_d.rresp = xmb_pkg::RESP_ERR;
      endcase
    end
    st_d.arready = !st_d.rvalid;
  end

  // one register for the whole record; reset clears lockout and 64k mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q            <= '0;
      st_q.ext_mode   <= 1'b0; // [R03]
      st_q.lockout    <= 1'b0; // [R09]
      st_q.key        <= xmb_pkg::KEY_RST;
      st_q.io_key     <= xmb_pkg::KEY_RST;
      st_q.mir        <= xmb_pkg::MIR_RST;
      st_q.cyc        <= xmb_pkg::CYC_IDLE;
      st_q.bresp      <= xmb_pkg::RESP_OK;
      st_q.rresp      <= xmb_pkg::RESP_OK;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the record
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign status_key    = st_q.status_key;
  assign uinstr_stall  = st_q.stall;
  assign mem_req       = st_q.mem_req;
  assign mem_we        = st_q.mem_we;
  assign mem_addr      = st_q.mem_addr;
  assign map_input     = st_q.map_input;
  assign lockout       = st_q.lockout;
  assign other_refuse  = st_q.other_refuse;
  assign prot_int      = st_q.prot_int;
  assign io_int_req    = st_q.io_int_req;

endmodule : xmb_top

//--- bench/xmb_properties.sv
// port-level assertions for the extended memory bus control block
`timescale 1ns/1ps
module xmb_properties
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // watched ports
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        cyc_start,
  input wire logic        page_zero_active,
  input wire logic        mem_req,
  input wire logic        mem_accept,
  input wire logic [15:0] mem_addr,
  input wire logic [18:0] map_input,
  input wire logic        other_req,
  input wire logic        other_lockout,
  input wire logic        lockout,
  input wire logic        other_refuse,
  input wire logic        prot_int,
  input wire logic        io_int_req,
  input wire logic        uinstr_stall
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // lockout held while the other port asks
  sequence s_shared;
    lockout && other_req;
  endsequence
  // both interrupts together, then prot_int gone
  sequence s_int_pulse;
    prot_int && io_int_req ##1 !prot_int;
  endsequence
  property p_refuse;
    s_shared |=> other_refuse;
  endproperty
  property p_no_refuse;
    !lockout |=> !other_refuse;
  endproperty
  property p_lock_win;
    $rose(lockout) |-> $past(mem_accept) && !$past(other_lockout);
  endproperty
  property p_lock_hold;
    lockout && !mem_accept |=> lockout;
  endproperty
  property p_page_zero;
    $rose(mem_req) && $past(page_zero_active) |-> !mem_addr[15];
  endproperty
  property p_map;
    mem_req |-> map_input[14:0] == mem_addr[14:0] && (map_input[15] || !mem_addr[15]);
  endproperty
  property p_prot;
    $rose(prot_int) |-> s_int_pulse;
  endproperty
  property p_stall;
    uinstr_stall |-> $past(cyc_start);
  endproperty
  // reset must be seen, so this one is not disabled by it
  property p_reset;
    disable iff (1'b0) !aresetn |=> !lockout && !mem_req;
  endproperty
  // write response stands until the master takes it
  property p_resp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("other port not refused");
  a_no_refuse: assert property (p_no_refuse) else $error("refused without lockout");
  a_lock_win: assert property (p_lock_win) else $error("lockout without a win");
  a_lock_hold: assert property (p_lock_hold) else $error("lockout dropped early");
  a_page_zero: assert property (p_page_zero) else $error("wide address on page zero");
  a_map: assert property (p_map) else $error("map input wrong");
  a_prot: assert property (p_prot) else $error("interrupt pair wrong");
  a_stall: assert property (p_stall) else $error("stall without request");
  a_reset: assert property (p_reset) else $error("reset kept lockout");
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped early");
endmodule : xmb_properties

bind xmb_top xmb_properties u_props (.*);

//--- bench/xmb_mem_model.sv
// memory control stand-in: grants cycles and returns read data
`timescale 1ns/1ps
module xmb_mem_model
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // cycle handshake
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  grant_delay,
  output logic             mem_accept,
  // read return and dma traffic
  input  wire logic [15:0] rd_word,
  input  wire logic        dma_go,
  output logic             rdata_valid,
  output logic             rdata_dma,
  output logic [15:0]      rdata
);
  logic [1:0] wait_q;
  logic [1:0] fly_q;
  // one-cycle grant so a request is won once; idle data bus keeps toggling
  always_ff @(posedge aclk)
  begin
    mem_accept  <= 1'b0;
    rdata_valid <= dma_go;
    rdata_dma   <= dma_go;
    rdata       <= dma_go ? ~rd_word : ~rdata;
    if (!aresetn)
    begin
      wait_q <= 2'h0;
      fly_q  <= 2'h0;
      rdata  <= 16'h0000;
    end
    else if (fly_q != 2'h0)
    begin
      fly_q <= fly_q - 2'h1;
      if (fly_q == 2'h1)
      begin
        rdata_valid <= 1'b1;
        rdata       <= rd_word;
      end
    end
    else if (mem_req && !mem_accept)
    begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == grant_delay)
      begin
        mem_accept <= 1'b1;
        wait_q     <= 2'h0;
        fly_q      <= mem_we ? 2'h0 : 2'h3;
      end
    end
  end
endmodule : xmb_mem_model

//--- bench/testbench.sv
// self-checking bench for the extended memory bus control block
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, uinstr_exec, transfer_bit;
  logic mode_flag_bit, page_zero_active, key_load, status_read, cyc_start, cyc_write;
  logic addr_from_mir, prot_violation, uinstr_stall, mem_req, mem_we, mem_accept, rdata_valid;
  logic rdata_dma, io_cycle_active, other_req, other_lockout, lockout, other_refuse;
  logic prot_int, io_int_req, dma_go;
  logic [1:0] s_axi_bresp, s_axi_rresp, sequence_select_code, latch_b_code, carry_ctrl_field;
  logic [1:0] grant_delay;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, micro_op_code, reg_a_spec, status_key;
  logic [15:0] alu_out, mem_addr_reg, mem_addr, rdata, rd_word, ma;
  logic [18:0] map_input, mi;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic acc, wv;
  int bad_count = 0;
  int n_checks = 0;
  int n_int = 0;

  xmb_top dut (.*);
  xmb_mem_model u_mem (.*);

  always #4 aclk = ~aclk;
  // counts interrupt pairs for the blocked-write check
  always @(posedge aclk)
    if (prot_int === 1'b1 && io_int_req === 1'b1) n_int++;

  task automatic end_of_test;
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(s_axi_bvalid && s_axi_bready))
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (!(s_axi_rvalid && s_axi_rready))
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // one memory cycle; address outputs captured at the grant
  task automatic cyc(input logic w, input logic [15:0] a);
    @(posedge aclk);
    cyc_start <= 1'b1;
    cyc_write <= w;
    mem_addr_reg <= a;
    @(posedge aclk);
    cyc_start <= 1'b0;
    for (int i = 0; i < 50 && mem_accept !== 1'b1; i++) @(posedge aclk);
    acc = mem_accept;
    wv = mem_we;
    ma = mem_addr;
    mi = map_input;
  endtask : cyc

  // one memory-control microinstruction word, then back to a no-op
  task automatic uop(input logic [1:0] cf, input logic [3:0] ra, input logic mf, input logic t);
    @(posedge aclk);
    micro_op_code <= 4'hD;
    latch_b_code <= 2'h3;
    carry_ctrl_field <= cf;
    reg_a_spec <= ra;
    mode_flag_bit <= mf;
    transfer_bit <= t;
    @(posedge aclk);
    micro_op_code <= 4'h0;
  endtask : uop

  task automatic regs_test;
    logic [31:0] d;
    logic [1:0] r;
    wr(xmb_pkg::OFF_IOKEY, 32'h5, r);
    rd(xmb_pkg::OFF_IOKEY, d, r);
    chk("iokey", 32'h5, d);
    wr(4'hC, 32'h1, r);
    chk("unmapped wr", xmb_pkg::RESP_ERR, r);
    rd(4'hC, d, r);
    chk("unmapped rd", xmb_pkg::RESP_ERR, r);
  endtask : regs_test

  task automatic key_test;
    @(posedge aclk);
    alu_out <= 16'hA000;
    key_load <= 1'b1;
    @(posedge aclk);
    key_load <= 1'b0;
    status_read <= 1'b1;
    @(posedge aclk);
    io_cycle_active <= 1'b1;
    #1 chk("key", 32'hA, status_key);
    @(posedge aclk);
    status_read <= 1'b0;
    #1 chk("io key", 32'h5, status_key);
    cyc(1'b1, 16'h0007);
    chk("io map", 32'h28007, mi);
    io_cycle_active <= 1'b0;
  endtask : key_test

  task automatic mode_test;
    logic [31:0] d;
    logic [1:0] r;
    uop(2'h0, 4'h0, 1'b1, 1'b1);
    rd(xmb_pkg::OFF_STATUS, d, r);
    chk("near miss", 32'h0, d[xmb_pkg::ST_EXT_MODE]);
    for (int c = 2; c < 4; c++)
    begin
      uop(2'h0, 4'h0, 1'b1, 1'b0);
      page_zero_active <= 1'b1;
      cyc(1'b1, 16'h8123);
      chk("page zero", 32'h0123, ma);
      page_zero_active <= 1'b0;
      cyc(1'b1, 16'h8123);
      chk("wide addr", 32'h8123, ma);
      chk("map", 32'h58123, mi);
      uop(c[1:0], {3'h0, c[0]}, 1'b0, 1'b0);
      cyc(1'b1, 16'h8123);
      chk("narrow", 32'h0123, ma);
    end
  endtask : mode_test

  task automatic prot_test;
    logic [31:0] d;
    logic [1:0] r;
    wr(xmb_pkg::OFF_CTRL, 32'h1, r);
    uop(2'h2, 4'h0, 1'b1, 1'b0);
    rd(xmb_pkg::OFF_STATUS, d, r);
    chk("prot on", 32'h1, d[xmb_pkg::ST_PROT_EN]);
    prot_violation <= 1'b1;
    cyc(1'b1, 16'h0100);
    chk("blocked", 32'h0, acc);
    chk("interrupts", 32'h1, n_int);
    wr(xmb_pkg::OFF_CTRL, 32'h2, r);
    cyc(1'b1, 16'h0100);
    chk("unprotected", 32'h1, acc);
    chk("write we", 32'h1, wv);
    prot_violation <= 1'b0;
  endtask : prot_test

  task automatic read_test;
    logic [31:0] d;
    logic [1:0] r;
    grant_delay <= 2'h3;
    cyc(1'b0, 16'h0040);
    @(posedge aclk);
    addr_from_mir <= 1'b1;
    cyc_start <= 1'b1;
    for (int i = 0; i < 50 && !uinstr_stall; i++) @(posedge aclk);
    chk("stall", 32'h1, uinstr_stall);
    // first cycle of the request: only the bypass can show the new word yet
    for (int i = 0; i < 50 && !mem_req; i++) @(posedge aclk);
    chk("mir addr", 32'h1234, mem_addr);
    chk("read we", 32'h0, mem_we);
    for (int i = 0; i < 50 && !mem_accept; i++) @(posedge aclk);
    cyc_start <= 1'b0;
    for (int i = 0; i < 50 && !rdata_valid; i++) @(posedge aclk);
    dma_go <= 1'b1;
    @(posedge aclk);
    dma_go <= 1'b0;
    addr_from_mir <= 1'b0;
    rd(xmb_pkg::OFF_STATUS, d, r);
    chk("mir", 32'h1234, d[31:16]);
  endtask : read_test

  task automatic lock_test;
    uop(2'h1, 4'h0, 1'b0, 1'b0);
    other_req <= 1'b1;
    #1 chk("lock early", 32'h0, lockout);
    cyc(1'b1, 16'h0010);
    repeat (2) @(posedge aclk);
    #1 chk("lock set", 32'h1, lockout);
    chk("refuse", 32'h1, other_refuse);
    uop(2'h0, 4'h1, 1'b0, 1'b0);
    #1 chk("release early", 32'h1, lockout);
    cyc(1'b1, 16'h0010);
    repeat (2) @(posedge aclk);
    #1 chk("released", 32'h0, lockout);
    chk("unrefused", 32'h0, other_refuse);
    uop(2'h1, 4'h0, 1'b0, 1'b0);
    cyc(1'b1, 16'h0010);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1 chk("reset lock", 32'h0, lockout);
  endtask : lock_test

  // other_lockout stays low: the second port never locks against us
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, transfer_bit,
     mode_flag_bit, page_zero_active, key_load, status_read, cyc_start, cyc_write,
     addr_from_mir, prot_violation, io_cycle_active, other_req, other_lockout, dma_go,
     sequence_select_code, latch_b_code, carry_ctrl_field, grant_delay, s_axi_awaddr,
     s_axi_araddr, micro_op_code, reg_a_spec, alu_out, mem_addr_reg, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    uinstr_exec = 1'b1;
    rd_word = 16'h1234;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    regs_test();
    key_test();
    mode_test();
    prot_test();
    read_test();
    lock_test();
    end_of_test();
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end
endmodule : testbench
